// [dcl_pkg.sv]
package dcl_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int NUM_CH     = 16;
  localparam int CH_W       = 4;
  localparam int ITER_W     = 15;
  localparam int ITER_SHORT = 9;

  // ----------------------------------------------------------------
  // Field positions of the iteration word (16 bits)
  // ----------------------------------------------------------------
  localparam int ITER_LINK_EN_BIT = 15;
  localparam int ITER_CH_LSB      = 9;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [NUM_CH-1:0] RST_FLAGS = 16'h0000;
  localparam logic [CH_W-1:0]   RST_CH    = 4'h0;

  typedef enum logic [2:0] {
    DCL_IDLE = 3'h1,
    DCL_RUN  = 3'h2,
    DCL_END  = 3'h4
  } dcl_state_e;

endpackage : dcl_pkg

// [dcl_channel_link.sv]
`timescale 1ns/1ps
// Overview of operation
// - When a loop ends with linking on, set the target channel's start bit.
// - A start bit set by a link raises a service request like software does.
// - Minor link fires after every major iteration except the final one.
// - At major loop end only major link enable and channel decide linking.
// - Minor target from minor link channel, major target from major link channel.
// - With minor link enabled the current count is nine bits.
// - With minor link disabled the current count is fifteen bits.
// - With minor link disabled the channel bits extend the count upward.
// - Flag a configuration error when current and beginning link enables differ.
// - Major link and scatter/gather enables are sampled at channel end.
// - After done, any descriptor write forces both enables to zero.
// - Done clears itself when the channel begins executing.
// - Start clears itself when the channel begins executing, unless software sets it in that same cycle.
module dcl_channel_link #(
  parameter int NUM_CH = dcl_pkg::NUM_CH,
  parameter int CH_W   = dcl_pkg::CH_W
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic [NUM_CH-1:0] sw_start_set,
  input  wire logic [NUM_CH-1:0] hw_request,
  input  wire logic [NUM_CH-1:0] sw_done_clr,
  input  wire logic              desc_wr,
  input  wire logic [CH_W-1:0]   desc_wr_ch,
  input  wire logic              desc_wr_major_link_en,
  input  wire logic [CH_W-1:0]   desc_wr_major_link_ch,
  input  wire logic              desc_wr_sg_en,
  input  wire logic [15:0]       desc_wr_current_iteration_count,
  input  wire logic [15:0]       desc_wr_beginning_iteration_count,
  input  wire logic              minor_done,
  output logic [NUM_CH-1:0]      start_flag,
  output logic [NUM_CH-1:0]      done_flag,
  output logic [NUM_CH-1:0]      major_link_en,
  output logic [NUM_CH-1:0]      sg_enable,
  output logic                   active,
  output logic [CH_W-1:0]        active_ch,
  output logic [14:0]            current_iteration_count,
  output logic                   config_error,
  output logic                   sg_load
);

  // ----------------------------------------------------------------
  // Descriptor storage
  // ----------------------------------------------------------------
  logic [CH_W-1:0] major_ch_mem [NUM_CH];
  logic [15:0]     current_iteration_count_mem    [NUM_CH];
  logic [15:0]     beginning_iteration_count_mem    [NUM_CH];

  function automatic logic [14:0] iter_count(input logic [15:0] w);
    if (w[dcl_pkg::ITER_LINK_EN_BIT]) iter_count = {6'h00, w[8:0]};
    else                              iter_count = w[14:0];
  endfunction : iter_count

  function automatic logic [15:0] iter_dec(input logic [15:0] w);
    if (w[dcl_pkg::ITER_LINK_EN_BIT]) iter_dec = {w[15:9], w[8:0] - 9'h001};
    else                              iter_dec = {w[15], w[14:0] - 15'h0001};
  endfunction : iter_dec

  // ----------------------------------------------------------------
  // Channel sequencing
  // ----------------------------------------------------------------
  dcl_pkg::dcl_state_e state_reg, state_next;
  logic [NUM_CH-1:0] start_reg, start_next, done_reg, done_next;
  logic [NUM_CH-1:0] mlink_reg, mlink_next, sg_reg, sg_next, hw_q1, hw_q2;
  logic [CH_W-1:0]   ch_reg, ch_next;
  logic              sgl_reg, sgl_next, cfg_reg, cfg_next;
  logic              act_reg, act_next;
  logic [NUM_CH-1:0] pend, link_set;
  logic              last_iter, grant;
  logic [CH_W-1:0]   grant_ch;
  logic [15:0]       cw;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hw_q1 <= dcl_pkg::RST_FLAGS;
      hw_q2 <= dcl_pkg::RST_FLAGS;
    end else begin
      hw_q1 <= hw_request;
      hw_q2 <= hw_q1;
    end
  end

  assign cw        = current_iteration_count_mem[ch_reg];
  assign last_iter = (iter_count(cw) == 15'h0001);
  assign pend      = start_reg | hw_q2;

  always_comb begin
    grant    = 1'b0;
    grant_ch = dcl_pkg::RST_CH;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (pend[i]) begin
        grant    = 1'b1;
        grant_ch = CH_W'(i);
      end
    end
  end

  always_comb begin
    state_next = state_reg;
    start_next = start_reg | sw_start_set;
    done_next  = done_reg & ~sw_done_clr;
    mlink_next = mlink_reg;
    sg_next    = sg_reg;
    ch_next    = ch_reg;
    sgl_next   = 1'b0;
    link_set   = '0;
    cfg_next   = (desc_wr_current_iteration_count[15] != desc_wr_beginning_iteration_count[15]) && desc_wr;
    if (desc_wr) begin
      if (done_reg[desc_wr_ch]) begin
        mlink_next[desc_wr_ch] = 1'b0;
        sg_next[desc_wr_ch]    = 1'b0;
      end else begin
        mlink_next[desc_wr_ch] = desc_wr_major_link_en;
        sg_next[desc_wr_ch]    = desc_wr_sg_en;
      end
    end
    case (state_reg)
      dcl_pkg::DCL_IDLE: begin
        if (grant) begin
          ch_next              = grant_ch;
          start_next[grant_ch] = sw_start_set[grant_ch];
          done_next[grant_ch]  = 1'b0;
          state_next           = dcl_pkg::DCL_RUN;
        end
      end
      dcl_pkg::DCL_RUN: begin
        if (minor_done) state_next = dcl_pkg::DCL_END;
      end
      dcl_pkg::DCL_END: begin
        if (!last_iter) begin
          if (cw[dcl_pkg::ITER_LINK_EN_BIT])
            link_set[cw[12:9]] = 1'b1;
        end else begin
          done_next[ch_reg] = 1'b1;
          if (mlink_reg[ch_reg]) link_set[major_ch_mem[ch_reg]] = 1'b1;
          sgl_next = sg_reg[ch_reg];
        end
        start_next = start_next | link_set;
        state_next = dcl_pkg::DCL_IDLE;
      end
      default: state_next = dcl_pkg::DCL_IDLE;
    endcase
    act_next = (state_next != dcl_pkg::DCL_IDLE);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= dcl_pkg::DCL_IDLE;
      start_reg <= dcl_pkg::RST_FLAGS;
      done_reg  <= dcl_pkg::RST_FLAGS;
      mlink_reg <= dcl_pkg::RST_FLAGS;
      sg_reg    <= dcl_pkg::RST_FLAGS;
      ch_reg    <= dcl_pkg::RST_CH;
      sgl_reg   <= 1'b0;
      cfg_reg   <= 1'b0;
      act_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      start_reg <= start_next;
      done_reg  <= done_next;
      mlink_reg <= mlink_next;
      sg_reg    <= sg_next;
      ch_reg    <= ch_next;
      sgl_reg   <= sgl_next;
      cfg_reg   <= cfg_next;
      act_reg   <= act_next;
    end
  end

  // Descriptor memory, no reset
  // Count update never lost to a write of another channel
  always_ff @(posedge clk) begin
    if (state_reg == dcl_pkg::DCL_END) begin
      current_iteration_count_mem[ch_reg] <= last_iter ? beginning_iteration_count_mem[ch_reg] : iter_dec(cw);
    end
    if (desc_wr) begin
      major_ch_mem[desc_wr_ch] <= desc_wr_major_link_ch;
      current_iteration_count_mem[desc_wr_ch]    <= desc_wr_current_iteration_count;
      beginning_iteration_count_mem[desc_wr_ch]    <= desc_wr_beginning_iteration_count;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic [14:0] cnt_reg;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) cnt_reg <= 15'h0000;
    else          cnt_reg <= iter_count(cw);
  end

  assign start_flag              = start_reg;
  assign done_flag               = done_reg;
  assign major_link_en           = mlink_reg;
  assign sg_enable               = sg_reg;
  assign active                  = act_reg;
  assign active_ch               = ch_reg;
  assign current_iteration_count = cnt_reg;
  assign config_error            = cfg_reg;
  assign sg_load                 = sgl_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_start_clr;
    @(posedge clk) disable iff (!reset_n)
      (state_reg == dcl_pkg::DCL_IDLE && grant && !sw_start_set[grant_ch])
      |=> !start_reg[$past(grant_ch)];
  endproperty
  a_start_clr: assert property (p_start_clr) else $error("start not cleared");

  property p_done_clr;
    @(posedge clk) disable iff (!reset_n)
      (state_reg == dcl_pkg::DCL_IDLE && grant) |=> !done_reg[$past(grant_ch)];
  endproperty
  a_done_clr: assert property (p_done_clr) else $error("done not cleared");

  property p_minor_link;
    @(posedge clk) disable iff (!reset_n)
      (state_reg == dcl_pkg::DCL_END && !last_iter && cw[15]) |=> start_reg[$past(cw[12:9])];
  endproperty
  a_minor_link: assert property (p_minor_link) else $error("minor link missed");

  property p_major_link;
    @(posedge clk) disable iff (!reset_n)
      (state_reg == dcl_pkg::DCL_END && last_iter && mlink_reg[ch_reg])
      |=> start_reg[$past(major_ch_mem[ch_reg])] && done_reg[$past(ch_reg)];
  endproperty
  a_major_link: assert property (p_major_link) else $error("major link missed");

  property p_wr_after_done;
    @(posedge clk) disable iff (!reset_n)
      (desc_wr && done_reg[desc_wr_ch]) |=> !mlink_reg[$past(desc_wr_ch)] && !sg_reg[$past(desc_wr_ch)];
  endproperty
  a_wr_after_done: assert property (p_wr_after_done) else $error("enable survived done");

  property p_cfg;
    @(posedge clk) disable iff (!reset_n)
      (desc_wr && desc_wr_current_iteration_count[15] != desc_wr_beginning_iteration_count[15]) |=> config_error;
  endproperty
  a_cfg: assert property (p_cfg) else $error("config error missed");

  property p_count_w;
    @(posedge clk) disable iff (!reset_n)
      cw[15] |=> current_iteration_count[14:9] == 6'h00;
  endproperty
  a_count_w: assert property (p_count_w) else $error("short count too wide");

  property p_serviced;
    @(posedge clk) disable iff (!reset_n)
      (state_reg == dcl_pkg::DCL_IDLE && grant) |=> active ##0 active_ch == $past(grant_ch);
  endproperty
  a_serviced: assert property (p_serviced) else $error("request not serviced");

  c_minor: cover property (@(posedge clk) state_reg == dcl_pkg::DCL_END && !last_iter && cw[15]);
  c_major: cover property (@(posedge clk) state_reg == dcl_pkg::DCL_END && last_iter && mlink_reg[ch_reg]);
  c_wrdone: cover property (@(posedge clk) desc_wr && done_reg[desc_wr_ch]);

endmodule : dcl_channel_link

// [test_dcl_channel_link.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, a, b); end end
module test_dcl_channel_link;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [15:0] sw_start_set = 16'h0000;
  logic [15:0] hw_request = 16'h0000;
  logic [15:0] sw_done_clr = 16'h0000;
  logic        desc_wr = 1'b0;
  logic [3:0]  desc_wr_ch = 4'h0;
  logic        desc_wr_major_link_en = 1'b0;
  logic [3:0]  desc_wr_major_link_ch = 4'h0;
  logic        desc_wr_sg_en = 1'b0;
  logic [15:0] desc_wr_current_iteration_count = 16'h0000;
  logic [15:0] desc_wr_beginning_iteration_count = 16'h0000;
  logic        minor_done = 1'b0;
  logic [15:0] start_flag, done_flag, major_link_en, sg_enable;
  logic        active, config_error, sg_load, cfg_seen;
  logic [3:0]  active_ch;
  logic [14:0] current_iteration_count;
  logic [15:0] v = 16'hB107;
  int          errors = 0;
  int          compares = 0;
  always #20 clk = ~clk;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_seen <= 1'b0;
    end else begin
      cfg_seen <= cfg_seen | config_error;
    end
  end
  dcl_channel_link dcl_channel_link_i (.clk(clk), .reset_n(reset_n), .sw_start_set(sw_start_set),
    .hw_request(hw_request), .sw_done_clr(sw_done_clr), .desc_wr(desc_wr), .desc_wr_ch(desc_wr_ch),
    .desc_wr_major_link_en(desc_wr_major_link_en), .desc_wr_major_link_ch(desc_wr_major_link_ch),
    .desc_wr_sg_en(desc_wr_sg_en), .desc_wr_current_iteration_count(desc_wr_current_iteration_count), .desc_wr_beginning_iteration_count(desc_wr_beginning_iteration_count),
    .minor_done(minor_done), .start_flag(start_flag), .done_flag(done_flag),
    .major_link_en(major_link_en), .sg_enable(sg_enable), .active(active), .active_ch(active_ch),
    .current_iteration_count(current_iteration_count), .config_error(config_error), .sg_load(sg_load));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr
  task automatic tick();
    @(posedge clk);
    #2;
  endtask : tick
  task automatic wr(input logic [3:0] ch, input logic mle, input logic [3:0] mch, input logic sg,
                    input logic [15:0] ci, input logic [15:0] bi);
    desc_wr = 1'b1;
    desc_wr_ch = ch;
    desc_wr_major_link_en = mle;
    desc_wr_major_link_ch = mch;
    desc_wr_sg_en = sg;
    desc_wr_current_iteration_count = ci;
    desc_wr_beginning_iteration_count = bi;
    tick();
    desc_wr = 1'b0;
    tick();
  endtask : wr
  task automatic kick(input logic [15:0] m);
    sw_start_set = m;
    tick();
    sw_start_set = 16'h0000;
  endtask : kick
  task automatic serve(input logic [3:0] ch);
    int n;
    n = 0;
    while (active !== 1'b1 && n < 20) begin
      tick();
      n++;
    end
    `CHK(active_ch, ch)
    repeat (3) tick();
  endtask : serve
  task automatic iter();
    int n;
    n = 0;
    minor_done = 1'b1;
    tick();
    minor_done = 1'b0;
    while (active !== 1'b0 && n < 10) begin
      tick();
      n++;
    end
    `CHK(active, 1'b0)
  endtask : iter
  task automatic stop_test();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    #(40 * 5000);
    errors++;
    stop_test();
  end
  initial begin
    repeat (16) @(posedge clk);
    #2;
    reset_n = 1'b1;
    `CHK({start_flag, done_flag, major_link_en, sg_enable, active}, 65'h0)
    for (int i = 0; i < 16; i++) wr(i[3:0], 1'b0, 4'h0, 1'b0, 16'h0001, 16'h0001);
    `CHK(cfg_seen, 1'b0)
    wr(4'h2, 1'b1, 4'h5, 1'b1, 16'h8403, 16'h8403);
    kick(16'h0004);
    serve(4'h2);
    `CHK(current_iteration_count, 15'h0003)
    `CHK(start_flag[2], 1'b0)
    for (int i = 0; i < 2; i++) begin
      iter();
      `CHK(start_flag[2], 1'b1)
      serve(4'h2);
    end
    iter();
    `CHK({start_flag[5], start_flag[2], done_flag[2], sg_load}, 4'hB)
    serve(4'h5);
    iter();
    `CHK(done_flag[5], 1'b1)
    wr(4'h2, 1'b1, 4'h7, 1'b1, 16'h0001, 16'h0001);
    `CHK({major_link_en[2], sg_enable[2]}, 2'b00)
    sw_done_clr = 16'h0004;
    tick();
    sw_done_clr = 16'h0000;
    `CHK(done_flag[2], 1'b0)
    wr(4'h2, 1'b0, 4'h7, 1'b0, 16'h0001, 16'h0001);
    kick(16'h0004);
    serve(4'h2);
    wr(4'h2, 1'b1, 4'h7, 1'b1, 16'h0001, 16'h0001);
    `CHK({major_link_en[2], sg_enable[2]}, 2'b11)
    iter();
    `CHK({start_flag[7], sg_load}, 2'b11)
    serve(4'h7);
    iter();
    kick(16'h0220);
    serve(4'h5);
    `CHK(done_flag[5], 1'b0)
    `CHK(start_flag[9], 1'b1)
    iter();
    serve(4'h9);
    iter();
    for (int i = 0; i < 3; i++) begin
      v = lfsr(v);
      wr(4'h3, 1'b0, 4'h0, 1'b0, {1'b0, v[14:0] | 15'h0002}, {1'b0, v[14:0] | 15'h0002});
      hw_request = 16'h0008;
      serve(4'h3);
      hw_request = 16'h0000;
      `CHK(current_iteration_count, v[14:0] | 15'h0002)
      iter();
    end
    wr(4'h8, 1'b0, 4'h0, 1'b0, 16'h8001, 16'h0001);
    tick();
    `CHK(cfg_seen, 1'b1)
    stop_test();
  end
endmodule : test_dcl_channel_link
